/* logic/cgu_regs.vh */
// Constants of the clock mode generation unit
`ifndef CGU_REGS_VH
`define CGU_REGS_VH

// ----------------------------------------------------------------------------
// Clock modes
// ----------------------------------------------------------------------------
`define CGU_MODE_W          2
`define CGU_MODE_DIRECT     2'h0
`define CGU_MODE_PRESCALER  2'h1
`define CGU_MODE_PLL        2'h2
`define CGU_MODE_PLL_BASE   2'h3

// ----------------------------------------------------------------------------
// Switch sequencer states
// ----------------------------------------------------------------------------
`define CGU_ST_W            2
`define CGU_ST_RUN          2'h0
`define CGU_ST_PARK         2'h1
`define CGU_ST_SETTLE       2'h2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CGU_RST_MODE        2'h0
`define CGU_RST_STATE       2'h0

`endif

/* logic/cgu_divider.v */
// Edge-counting clock divider with factor taken only at period end
`timescale 1ns/1ps

module cgu_divider #(
   parameter FW = 8
) (
   input  wire          clock,
   input  wire          rst,
   input  wire          source,
   input  wire [FW-1:0] factor,
   output reg           out_level
);

   reg          source_q;
   reg [FW-1:0] count;
   reg [FW-1:0] held;
   wire         rise;
   wire [FW-1:0] last;
   wire [FW-1:0] next_count;
   wire [FW-1:0] half;
   wire         wrap;

   assign rise       = source & ~source_q;
   assign last       = (held <= {{(FW-1){1'b0}}, 1'b1}) ? {FW{1'b0}} : held - 1'b1;
   assign wrap       = (count >= last);
   assign next_count = wrap ? {FW{1'b0}} : count + 1'b1;
   assign half       = held >> 1;

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         source_q  <= 1'b0;
         count     <= {FW{1'b0}};
         held      <= {{(FW-1){1'b0}}, 1'b1};
         out_level <= 1'b0;
      end else begin
         source_q <= source;
         if (rise) begin
            count <= next_count;
            // New factor only at a period boundary
            if (wrap)
               held <= (factor == {FW{1'b0}}) ? {{(FW-1){1'b0}}, 1'b1} : factor;
         end
         if (held <= {{(FW-1){1'b0}}, 1'b1})
            out_level <= source;
         else if (rise)
            out_level <= (next_count < half);
      end
   end

endmodule // cgu_divider

/* logic/cgu_clock_mode_generation_unit.v */
// Clock mode generation: dividers, phase detector, safe mode switch, gating
`timescale 1ns/1ps
`include "cgu_regs.vh"

module cgu_clock_mode_generation_unit #(
   parameter PW      = 4,
   parameter NW      = 8,
   parameter KW      = 4,
   parameter MODULES = 4
) (
   input  wire                  clock,
   input  wire                  rst,
   input  wire                  oscillator_input_pin,
   input  wire                  vco_clock,
   input  wire [`CGU_MODE_W-1:0] hw_mode_strap,
   input  wire                  mode_by_software,
   input  wire [`CGU_MODE_W-1:0] sw_mode,
   input  wire [PW-1:0]         p_factor,
   input  wire [NW-1:0]         n_factor,
   input  wire [KW-1:0]         k_factor,
   input  wire                  sleep_request,
   input  wire                  power_down_request,
   input  wire [MODULES-1:0]    sleep_run_mask,
   output reg                   cpu_clock,
   output reg                   system_bus_clock,
   output reg  [MODULES-1:0]    module_clock,
   output reg                   vco_enable,
   output reg                   vco_base_mode,
   output reg                   pll_up,
   output reg                   pll_down,
   output reg  [`CGU_MODE_W-1:0] active_mode,
   output wire                  switch_busy
);

   // -------------------------------------------------------------------------
   // Mode request
   // -------------------------------------------------------------------------
   reg [`CGU_MODE_W-1:0] strap_mode;
   reg                   strap_taken;
   wire [`CGU_MODE_W-1:0] requested;

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         strap_mode  <= `CGU_RST_MODE;
         strap_taken <= 1'b0;
      end else if (!strap_taken) begin
         // Strap caught on the first edge after release
         strap_mode  <= hw_mode_strap;
         strap_taken <= 1'b1;
      end
   end

   assign requested = mode_by_software ? sw_mode : strap_mode;

   // -------------------------------------------------------------------------
   // Divider chain
   // -------------------------------------------------------------------------
   wire osc_div_p;
   wire pre_div_k;
   wire vco_div_n;
   wire vco_div_k;

   cgu_divider #(.FW(PW)) u_p_div (
      .clock     (clock),
      .rst       (rst),
      .source    (oscillator_input_pin),
      .factor    (p_factor),
      .out_level (osc_div_p)
   );

   cgu_divider #(.FW(KW)) u_k_pre (
      .clock     (clock),
      .rst       (rst),
      .source    (osc_div_p),
      .factor    (k_factor),
      .out_level (pre_div_k)
   );

   cgu_divider #(.FW(NW)) u_n_div (
      .clock     (clock),
      .rst       (rst),
      .source    (vco_clock),
      .factor    (n_factor),
      .out_level (vco_div_n)
   );

   cgu_divider #(.FW(KW)) u_k_vco (
      .clock     (clock),
      .rst       (rst),
      .source    (vco_clock),
      .factor    (k_factor),
      .out_level (vco_div_k)
   );

   // -------------------------------------------------------------------------
   // Phase detector between P-divided reference and N-divided feedback
   // -------------------------------------------------------------------------
   reg  ref_q;
   reg  fb_q;
   wire ref_rise;
   wire fb_rise;
   wire loop_on;

   assign ref_rise = osc_div_p & ~ref_q;
   assign fb_rise  = vco_div_n & ~fb_q;
   assign loop_on  = (active_mode == `CGU_MODE_PLL) && !power_down_request;

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         ref_q    <= 1'b0;
         fb_q     <= 1'b0;
         pll_up   <= 1'b0;
         pll_down <= 1'b0;
      end else begin
         ref_q <= osc_div_p;
         fb_q  <= vco_div_n;
         if (!loop_on) begin
            pll_up   <= 1'b0;
            pll_down <= 1'b0;
         end else if ((ref_rise | pll_up) & (fb_rise | pll_down)) begin
            // Both edges seen: reset the detector
            pll_up   <= 1'b0;
            pll_down <= 1'b0;
         end else begin
            pll_up   <= pll_up | ref_rise;
            pll_down <= pll_down | fb_rise;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Source select
   // -------------------------------------------------------------------------
   reg [`CGU_MODE_W-1:0] target;
   reg                   select_level;
   reg                   target_level;

   function mode_level;
      input [`CGU_MODE_W-1:0] mode;
      input                   direct;
      input                   pre;
      input                   vco;
      begin
         case (mode)
            `CGU_MODE_DIRECT:    mode_level = direct;
            `CGU_MODE_PRESCALER: mode_level = pre;
            `CGU_MODE_PLL:       mode_level = vco;
            `CGU_MODE_PLL_BASE:  mode_level = vco;
            default:             mode_level = direct;
         endcase
      end
   endfunction

   always @* begin
      select_level = mode_level(active_mode, oscillator_input_pin, pre_div_k, vco_div_k);
      target_level = mode_level(target, oscillator_input_pin, pre_div_k, vco_div_k);
   end

   // -------------------------------------------------------------------------
   // Switch sequencer
   // -------------------------------------------------------------------------
   reg [`CGU_ST_W-1:0] state;
   reg                 source_gate;
   wire                mux_level;

   assign mux_level   = select_level & source_gate;
   assign switch_busy = (state != `CGU_ST_RUN);

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         state       <= `CGU_RST_STATE;
         active_mode <= `CGU_RST_MODE;
         target      <= `CGU_RST_MODE;
         source_gate <= 1'b1;
      end else begin
         case (state)
            `CGU_ST_RUN: begin
               if (strap_taken && requested != active_mode) begin
                  target <= requested;
                  state  <= `CGU_ST_PARK;
               end
            end
            `CGU_ST_PARK: begin
               // Old source parked only while low
               if (!select_level) begin
                  source_gate <= 1'b0;
                  active_mode <= target;
                  state       <= `CGU_ST_SETTLE;
               end
            end
            `CGU_ST_SETTLE: begin
               // New source released only while low, next pulse is whole
               if (!target_level) begin
                  source_gate <= 1'b1;
                  state       <= `CGU_ST_RUN;
               end
            end
            default: begin
               state       <= `CGU_ST_RUN;
               source_gate <= 1'b1;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // VCO control
   // -------------------------------------------------------------------------
   reg sys_gate;

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         vco_enable    <= 1'b0;
         vco_base_mode <= 1'b0;
      end else begin
         // VCO stops only once the gates closed on a low level
         vco_enable    <= !power_down_request | sys_gate;
         vco_base_mode <= (target == `CGU_MODE_PLL_BASE);
      end
   end

   // -------------------------------------------------------------------------
   // Output gating for sleep and power-down
   // -------------------------------------------------------------------------
   reg               cpu_gate;
   reg [MODULES-1:0] module_gate;

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         cpu_gate         <= 1'b1;
         sys_gate         <= 1'b1;
         cpu_clock        <= 1'b0;
         system_bus_clock <= 1'b0;
      end else begin
         // Gates move only while the selected clock is low
         if (!mux_level) begin
            cpu_gate <= !(sleep_request | power_down_request);
            sys_gate <= !power_down_request;
         end
         cpu_clock        <= mux_level & cpu_gate;
         system_bus_clock <= mux_level & sys_gate;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < MODULES; gi = gi + 1) begin : g_module
         always @(posedge clock or posedge rst) begin
            if (rst) begin
               module_gate[gi]  <= 1'b1;
               module_clock[gi] <= 1'b0;
            end else begin
               if (!mux_level)
                  module_gate[gi] <= !power_down_request &
                                     (!sleep_request | sleep_run_mask[gi]);
               module_clock[gi] <= mux_level & module_gate[gi];
            end
         end
      end
   endgenerate

endmodule // cgu_clock_mode_generation_unit

/* dv/cgu_chk.sv */
// Assertion checker of the clock mode generation unit
`timescale 1ns/1ps
`include "cgu_regs.vh"
module cgu_chk #(
   parameter PW      = 4,
   parameter NW      = 8,
   parameter KW      = 4,
   parameter MODULES = 4
) (
   input wire                   clock,
   input wire                   rst,
   input wire                   mode_by_software,
   input wire [`CGU_MODE_W-1:0] sw_mode,
   input wire                   sleep_request,
   input wire                   power_down_request,
   input wire [MODULES-1:0]     sleep_run_mask,
   input wire                   cpu_clock,
   input wire                   system_bus_clock,
   input wire [MODULES-1:0]     module_clock,
   input wire                   vco_enable,
   input wire                   pll_up,
   input wire                   pll_down,
   input wire [`CGU_MODE_W-1:0] active_mode,
   input wire                   switch_busy
);
   logic [2:0] age;
   logic [7:0] pd_n, sl_n, rn_n;
   // Cycles since reset, in power-down, in sleep, in plain run
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         age  <= 3'h0;
         pd_n <= 8'h00;
         sl_n <= 8'h00;
         rn_n <= 8'h00;
      end else begin
         age  <= age + {2'h0, age != 3'h7};
         pd_n <= power_down_request ? pd_n + {7'h00, pd_n != 8'hff} : 8'h00;
         sl_n <= sleep_request ? sl_n + {7'h00, sl_n != 8'hff} : 8'h00;
         rn_n <= (sleep_request | power_down_request | switch_busy) ? 8'h00
                 : rn_n + {7'h00, rn_n != 8'hff};
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   property p_vco_en;
      age > 3'h1 && !$past(power_down_request) |-> vco_enable;
   endproperty
   a_vco_en: assert property (p_vco_en)
      else $error("vco enable not following power-down");
   property p_vco_off;
      pd_n > 8'h40 |-> !vco_enable;
   endproperty
   a_vco_off: assert property (p_vco_off)
      else $error("vco still enabled in power-down");
   property p_pll_off;
      (active_mode != `CGU_MODE_PLL || power_down_request) |=> !pll_up && !pll_down;
   endproperty
   a_pll_off: assert property (p_pll_off)
      else $error("phase detector active outside pll mode");
   property p_take;
      age > 3'h3 && mode_by_software && !switch_busy && sw_mode != active_mode |=> switch_busy;
   endproperty
   a_take: assert property (p_take)
      else $error("mode request not taken");
   property p_busy_end;
      $rose(switch_busy) |-> ##[1:300] !switch_busy;
   endproperty
   a_busy_end: assert property (p_busy_end)
      else $error("switch never finished");
   property p_mode_hold;
      age > 3'h3 && !switch_busy |=> $stable(active_mode);
   endproperty
   a_mode_hold: assert property (p_mode_hold)
      else $error("mode changed outside a switch");
   property p_runt;
      $rose(cpu_clock) |=> cpu_clock;
   endproperty
   a_runt: assert property (p_runt)
      else $error("truncated cpu clock pulse");
   property p_pd_stop;
      pd_n > 8'h40 |-> !cpu_clock && !system_bus_clock && module_clock == '0;
   endproperty
   a_pd_stop: assert property (p_pd_stop)
      else $error("clocks running in power-down");
   property p_sleep;
      sl_n > 8'h40 && !power_down_request |-> !cpu_clock && (module_clock & ~sleep_run_mask) == '0;
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("gated clocks running in sleep");
   property p_sys_eq;
      rn_n > 8'h40 |-> system_bus_clock == cpu_clock;
   endproperty
   a_sys_eq: assert property (p_sys_eq)
      else $error("system clock differs from cpu clock");
endmodule // cgu_chk

/* dv/cgu_osc_model.sv */
// Oscillator and analog VCO stand-in facing the clock unit
`timescale 1ns/1ps
module cgu_osc_model #(
   parameter OSC_HALF  = 4,
   parameter BASE_HALF = 3
) (
   input  wire       clock,
   input  wire       vco_enable,
   input  wire       vco_base_mode,
   input  wire [3:0] p_factor,
   input  wire [7:0] n_factor,
   output reg        oscillator_input_pin,
   output reg        vco_clock
);
   integer oc = 0;
   integer vc = 0;
   integer vh;
   initial begin
      oscillator_input_pin = 1'b0;
      vco_clock = 1'b0;
   end
   // Crystal runs free; locked VCO runs at oscillator / P * N
   always @(posedge clock) begin
      vh = vco_base_mode ? BASE_HALF : OSC_HALF * p_factor / n_factor;
      oc = oc + 1;
      vc = vc + 1;
      if (oc >= OSC_HALF) begin
         oc = 0;
         oscillator_input_pin <= #1 ~oscillator_input_pin;
      end
      if (!vco_enable) begin
         vc = 0;
         vco_clock <= #1 1'b0;
      end else if (vc >= vh) begin
         vc = 0;
         vco_clock <= #1 ~vco_clock;
      end
   end
endmodule // cgu_osc_model

/* dv/tb.sv */
// Self-checking bench of the clock mode generation unit
`timescale 1ns/1ps
`include "cgu_regs.vh"
`define CHK(nm, e, g) \
   begin \
      n_compared = n_compared + 1; \
      if ((g) !== (e)) begin \
         err_count = err_count + 1; \
         $display("unexpected %s: expected %0h, seen %0h", nm, e, g); \
      end \
   end
module tb;
   reg        clock;
   reg        rst = 1'b1;
   reg  [1:0] hw_mode_strap = 2'h0;
   reg        mode_by_software = 1'b0;
   reg  [1:0] sw_mode = 2'h0;
   reg  [3:0] p_factor = 4'h2;
   reg  [7:0] n_factor = 8'h04;
   reg  [3:0] k_factor = 4'h3;
   reg        sleep_request = 1'b0;
   reg        power_down_request = 1'b0;
   reg  [3:0] sleep_run_mask = 4'h5;
   wire       oscillator_input_pin, vco_clock, cpu_clock, system_bus_clock;
   wire [3:0] module_clock;
   wire       vco_enable, vco_base_mode, pll_up, pll_down, switch_busy;
   wire [1:0] active_mode;
   integer    err_count = 0, n_compared = 0, cyc = 0, cpu_t = 0, sys_t = 0;
   integer    cpu_per = 0, sys_per = 0, sys_r = 0;
   reg  [5:0] act = 6'h00, rise = 6'h00, q = 6'h00;
   cgu_clock_mode_generation_unit uut (.*);
   cgu_osc_model osc (.*);
   // Periods and activity of the clock outputs
   always @(negedge clock) begin
      cyc = cyc + 1;
      rise = {cpu_clock, system_bus_clock, module_clock} & ~q;
      q = {cpu_clock, system_bus_clock, module_clock};
      act = act | rise;
      if (rise[5]) begin
         cpu_per = cyc - cpu_t;
         cpu_t = cyc;
      end
      if (rise[4]) begin
         sys_per = cyc - sys_t;
         sys_t = cyc;
         sys_r = sys_r + 1;
      end
   end
   task tick;
      begin
         @(posedge clock);
         #1;
      end
   endtask
   task settle;
      integer i;
      begin
         i = 0;
         repeat (2) tick;
         while (switch_busy !== 1'b0 && i < 500) begin
            tick;
            i = i + 1;
         end
         i = sys_r + 3;
         repeat (600) if (sys_r < i) tick;
         `CHK("switch_busy", 1'b0, switch_busy)
      end
   endtask
   task do_reset;
      begin
         rst = 1'b1;
         repeat (20) tick;
         rst = 1'b0;
         settle;
      end
   endtask
   task t_mode(input [1:0] m, input integer per);
      begin
         sw_mode = m;
         settle;
         `CHK("active_mode", m, active_mode)
         `CHK("cpu_period", per, cpu_per)
         `CHK("sys_period", per, sys_per)
      end
   endtask
   task t_back;
      begin
         sw_mode = `CGU_MODE_PRESCALER;
         tick;
         sw_mode = `CGU_MODE_PLL;
         settle;
         settle;
         `CHK("active_mode", `CGU_MODE_PLL, active_mode)
         `CHK("cpu_period", 12, cpu_per)
      end
   endtask
   task t_gate(input s, input d, input [5:0] exp);
      begin
         sleep_request = s;
         power_down_request = d;
         repeat (100) tick;
         act = 6'h00;
         repeat (100) tick;
         `CHK("clock_activity", exp, act)
         `CHK("vco_enable", !d, vco_enable)
      end
   endtask
   task t_strap;
      begin
         mode_by_software = 1'b0;
         hw_mode_strap = `CGU_MODE_PLL_BASE;
         do_reset;
         `CHK("active_mode", `CGU_MODE_PLL_BASE, active_mode)
         `CHK("vco_base_mode", 1'b1, vco_base_mode)
         `CHK("sys_period", 18, sys_per)
         `CHK("pll_up", 1'b0, pll_up)
         `CHK("pll_down", 1'b0, pll_down)
      end
   endtask
   task t_factor;
      begin
         k_factor = 4'h2;
         settle;
         `CHK("cpu_period", 12, cpu_per)
         `CHK("sys_period", 12, sys_per)
      end
   endtask
   task finish_test;
      begin
         $display("compared %0d, mismatches %0d", n_compared, err_count);
         if (err_count == 0 && n_compared > 0) begin
            $display("No errors found");
         end else begin
            $display("Errors were found");
         end
         $finish;
      end
   endtask
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial begin
      #100000;
      err_count = err_count + 1;
      finish_test;
   end
   initial begin
      do_reset;
      mode_by_software = 1'b1;
      t_mode(`CGU_MODE_DIRECT, 8);
      t_mode(`CGU_MODE_PRESCALER, 48);
      t_mode(`CGU_MODE_PLL, 12);
      t_mode(`CGU_MODE_PLL_BASE, 18);
      t_back;
      t_gate(1'b1, 1'b0, 6'h15);
      t_gate(1'b0, 1'b1, 6'h00);
      t_gate(1'b0, 1'b0, 6'h3f);
      t_strap;
      t_factor;
      finish_test;
   end
endmodule // tb
bind cgu_clock_mode_generation_unit cgu_chk #(.PW(PW), .NW(NW), .KW(KW), .MODULES(MODULES)) chk (.*);
